/* File: logic/gain_mix_pkg.sv */
// Shared constants and types for the input gain and left mixer registers
package gain_mix_pkg;

  // Bus widths
  localparam int DATA_W = 32;
  localparam int ADDR_W = 10;
  localparam int REG_W = 16;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_LEFT_GAIN = 8'h50;
  localparam logic [7:0] IDX_RIGHT_GAIN = 8'h51;
  localparam logic [7:0] IDX_LEFT_MIX = 8'h58;
  localparam logic [7:0] IDX_GAIN_STATUS = 8'h5F;

  // Gain register field positions
  localparam int GAIN_ON_BIT = 15;
  localparam int GAIN_SILENCE_BIT = 14;
  localparam int GAIN_ZC_BIT = 13;
  localparam int GAIN_COMMIT_BIT = 8;
  localparam int LEVEL_LSB = 2;
  localparam int LEVEL_W = 6;

  // Mixer select field positions
  localparam int MIX_ON_BIT = 15;
  localparam int MIX_RCONV_BIT = 12;
  localparam int MIX_LCONV_BIT = 11;
  localparam int MIX_AUX_BIT = 2;
  localparam int MIX_RGAIN_BIT = 1;
  localparam int MIX_LGAIN_BIT = 0;

  // Status register field positions
  localparam int STAT_RPEND_BIT = 15;
  localparam int STAT_LPEND_BIT = 14;
  localparam int STAT_RLEVEL_LSB = 8;
  localparam int STAT_LLEVEL_LSB = 0;

  // Values after reset
  localparam logic [5:0] LEVEL_RESET = 6'h10;
  localparam logic [8:0] QDB_RESET = 9'h000;

  // Gain law in quarter dB: floor -12dB, step 0.75dB
  localparam int QDB_W = 9;
  localparam logic [8:0] GAIN_FLOOR_QDB = 9'h1D0;
  localparam logic [8:0] GAIN_STEP_QDB = 9'h003;

  // Software view of one gain stage
  typedef struct packed {
    logic on;
    logic silence;
    logic zero_cross;
    logic [LEVEL_W-1:0] level;
  } gain_ctrl_s;

  // Gain stage controls handed to the analogue side
  typedef struct packed {
    logic on;
    logic silence;
    logic [LEVEL_W-1:0] level;
    logic [QDB_W-1:0] qdb;
    logic pending;
  } gain_out_s;

  // Left output mixer source selection
  typedef struct packed {
    logic on;
    logic right_converter_to_left_mix;
    logic left_converter_to_left_mix;
    logic aux_left_to_left_mix;
    logic right_gain_to_left_mix;
    logic left_gain_to_left_mix;
  } mix_sel_s;

  localparam mix_sel_s MIX_RESET = 6'h08;

  // Bus handshake states, Gray along idle to answer
  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } bus_e;

endpackage

/* File: logic/gain_stage_apply.sv */
// One gain stage: holds a committed level until it may be applied
`timescale 1ns/1ps
module gain_stage_apply (
  input wire logic clock,
  input wire logic rst,
  input wire logic commit,
  input wire logic [gain_mix_pkg::LEVEL_W-1:0] target,
  input wire logic zc_on,
  input wire logic zero_cross,
  output logic [gain_mix_pkg::LEVEL_W-1:0] level,
  output logic [gain_mix_pkg::QDB_W-1:0] qdb,
  output logic pending
);
  import gain_mix_pkg::*;

  // Whole state of the stage
  typedef struct packed {
    logic [LEVEL_W-1:0] level;
    logic [QDB_W-1:0] qdb;
    logic [LEVEL_W-1:0] held;
    logic pending;
  } stage_s;

  stage_s s_q;
  stage_s s_d;

  // Code to quarter dB: floor plus three per step
  function automatic logic [QDB_W-1:0] to_qdb(logic [LEVEL_W-1:0] c);
    return QDB_W'(GAIN_FLOOR_QDB + QDB_W'(c) * GAIN_STEP_QDB); // R7
  endfunction

  // Next state
  always_comb begin
    s_d = s_q;
    if (commit) begin
      // New commit replaces any level still waiting
      s_d.held = target;
      if (zc_on) begin
        s_d.pending = 1'b1; // R4
      end else begin
        s_d.level = target; // R3
        s_d.qdb = to_qdb(target);
        s_d.pending = 1'b0;
      end
    end else if (s_q.pending && (zero_cross || !zc_on)) begin
      // Crossing seen, or deferral switched off meanwhile
      s_d.level = s_q.held; // R4
      s_d.qdb = to_qdb(s_q.held);
      s_d.pending = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (rst) begin
      s_q.level <= LEVEL_RESET; // R8
      s_q.qdb <= QDB_RESET;
      s_q.held <= LEVEL_RESET;
      s_q.pending <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level = s_q.level;
  assign qdb = s_q.qdb;
  assign pending = s_q.pending;

endmodule // gain_stage_apply

/* File: logic/input_gain_and_left_mixer_regs.sv */
// Input gain stage and left output mixer control registers
// What this block does
// R1 - Bit 15 powers each gain stage on
// R2 - Bit 14 mutes stage, cuts record path
// R3 - Zero-cross off: new gain applies at once
// R4 - Left zero-cross on: wait for next crossing
// R5 - Right register mirrors left, own stage except the shared commit
// R6 - Levels wait for commit bit 8 write
// R7 - Level code -12dB up 0.75dB per step
// R8 - Level resets to 010000, 0dB
// R9 - Mixer bit 15 enables left output mixer
// R10 - Mixer bit 12 adds right converter
// R11 - Mixer bit 11 adds left converter, default on
// R12 - Mixer bit 2 adds third left input
// R13 - Mixer bit 1 adds right gain stage
// R14 - Mixer bit 0 adds left gain stage
// R15 - Undefined bits read zero, writes ignored
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ps
module input_gain_and_left_mixer_regs (
  input wire logic clock,
  input wire logic rst,
  input wire logic [gain_mix_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [gain_mix_pkg::DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [gain_mix_pkg::DATA_W-1:0] readdata,
  output logic waitrequest,
  input wire logic left_zero_cross,
  input wire logic right_zero_cross,
  output gain_mix_pkg::gain_out_s left_gain,
  output gain_mix_pkg::gain_out_s right_gain,
  output gain_mix_pkg::mix_sel_s left_mix
);
  import gain_mix_pkg::*;

  // Map in brief, as word indices:
  //   0x50 left gain, 0x51 right gain
  //   0x58 left mixer select, 0x5F status, read-only
  // Byte address is four times the index; bits 1:0 are ignored.
  // Levels written by software only reach the stages on a commit;
  // the commit bit is an action, never stored, and reads back zero.
  // Every access costs two cycles: one stall, one answer. Simple
  // and slow, which suits a block touched a few times per second.

  // Channel numbering for the per-stage loop
  // Left first, so status and arrays share one order
  localparam int CH_LEFT = 0;
  localparam int CH_RIGHT = 1;
  localparam int CH_N = 2;

  // Whole register-side state
  typedef struct packed {
    // Handshake phase
    bus_e bus;
    // Stall flag kept in a flop so the port is glitch free
    logic waitrequest;
    // Read answer, cleared on writes
    logic [DATA_W-1:0] rdata;
    // Software view of the left gain register
    gain_ctrl_s left;
    // Software view of the right gain register
    gain_ctrl_s right;
    // Mixer source selection
    mix_sel_s mix;
    // One-cycle commit pulse to both stages
    logic commit;
  } regs_state_s;

  regs_state_s s_q;
  regs_state_s s_d;

  // Word index taken from the byte address
  // All eight upper address bits decode, so no aliases
  logic [7:0] idx;

  // Request present while the slave is still stalling
  logic take;

  // Write data merged with old contents per byte lane
  logic [REG_W-1:0] merged;

  // Per-stage connections to the apply logic
  // Arrays keep both stages in one generate loop
  logic [CH_N-1:0] zc_in;
  logic [CH_N-1:0] zc_en;
  logic [CH_N-1:0] stage_pend;
  logic [LEVEL_W-1:0] stage_target [CH_N];
  logic [LEVEL_W-1:0] stage_level [CH_N];
  logic [QDB_W-1:0] stage_qdb [CH_N];

  // Gain control to register image; undefined bits zero
  function automatic logic [REG_W-1:0] pack_gain(gain_ctrl_s g);
    logic [REG_W-1:0] w;
    w = '0; // R15
    // Commit bit 8 deliberately left zero
    w[GAIN_ON_BIT] = g.on;
    w[GAIN_SILENCE_BIT] = g.silence;
    w[GAIN_ZC_BIT] = g.zero_cross;
    w[LEVEL_LSB +: LEVEL_W] = g.level;
    return w;
  endfunction

  // Register image to gain control, defined bits only
  function automatic gain_ctrl_s unpack_gain(logic [REG_W-1:0] w);
    gain_ctrl_s g;
    // Bits outside the fields are dropped here
    g.on = w[GAIN_ON_BIT]; // R1
    g.silence = w[GAIN_SILENCE_BIT]; // R2
    g.zero_cross = w[GAIN_ZC_BIT];
    g.level = w[LEVEL_LSB +: LEVEL_W];
    return g;
  endfunction

  // Mixer select to register image
  function automatic logic [REG_W-1:0] pack_mix(mix_sel_s m);
    logic [REG_W-1:0] w;
    w = '0; // R15
    // Bits 14, 13 and 10 to 3 stay zero
    w[MIX_ON_BIT] = m.on;
    w[MIX_RCONV_BIT] = m.right_converter_to_left_mix;
    w[MIX_LCONV_BIT] = m.left_converter_to_left_mix;
    w[MIX_AUX_BIT] = m.aux_left_to_left_mix;
    w[MIX_RGAIN_BIT] = m.right_gain_to_left_mix;
    w[MIX_LGAIN_BIT] = m.left_gain_to_left_mix;
    return w;
  endfunction

  // Register image to mixer select
  function automatic mix_sel_s unpack_mix(logic [REG_W-1:0] w);
    mix_sel_s m;
    // Undefined bits never reach the mixer
    m.on = w[MIX_ON_BIT]; // R9
    m.right_converter_to_left_mix = w[MIX_RCONV_BIT]; // R10
    m.left_converter_to_left_mix = w[MIX_LCONV_BIT]; // R11
    m.aux_left_to_left_mix = w[MIX_AUX_BIT]; // R12
    m.right_gain_to_left_mix = w[MIX_RGAIN_BIT]; // R13
    m.left_gain_to_left_mix = w[MIX_LGAIN_BIT]; // R14
    return m;
  endfunction

  // Status word: applied levels and waiting flags
  // Lets software see whether a deferred level still waits
  function automatic logic [REG_W-1:0] pack_status();
    logic [REG_W-1:0] w;
    w = '0;
    w[STAT_RPEND_BIT] = stage_pend[CH_RIGHT];
    w[STAT_LPEND_BIT] = stage_pend[CH_LEFT];
    w[STAT_RLEVEL_LSB +: LEVEL_W] = stage_level[CH_RIGHT];
    w[STAT_LLEVEL_LSB +: LEVEL_W] = stage_level[CH_LEFT];
    return w;
  endfunction

  // Read mux; unmapped words answer zero
  function automatic logic [REG_W-1:0] read_word(logic [7:0] i);
    logic [REG_W-1:0] w;
    w = '0;
    unique case (i)
      IDX_LEFT_GAIN: begin
        // Left image; commit bit reads zero
        w = pack_gain(s_q.left);
      end
      IDX_RIGHT_GAIN: begin
        // Right image, same layout
        w = pack_gain(s_q.right); // R5
      end
      IDX_LEFT_MIX: begin
        // Mixer select image
        w = pack_mix(s_q.mix);
      end
      IDX_GAIN_STATUS: begin
        // Applied levels, not the written ones
        w = pack_status();
      end
      default: begin
        // Hole in the map
        w = '0;
      end
    endcase
    return w;
  endfunction

  // Byte-lane merge against the addressed register
  function automatic logic [REG_W-1:0] lane_merge(
    logic [REG_W-1:0] old,
    logic [DATA_W-1:0] wd,
    logic [3:0] be
  );
    logic [REG_W-1:0] w;
    w = old;
    // Lane 0 carries the level field
    if (be[0]) begin
      w[7:0] = wd[7:0];
    end
    // Lane 1 carries the control bits and commit
    if (be[1]) begin
      w[15:8] = wd[15:8];
    end
    // Lanes 2 and 3 would hit bits that do not exist
    return w;
  endfunction

  // Decode and handshake terms
  always_comb begin
    idx = address[ADDR_W-1:2];
    take = (read || write) && (s_q.bus == BUS_IDLE);
    // Old contents supply the lanes the master leaves out
    merged = lane_merge(read_word(idx), writedata, byteenable);
  end

  // Register next state
  always_comb begin
    s_d = s_q;
    s_d.commit = 1'b0;
    // Two phases only, both legal, so no default
    unique case (s_q.bus)
      BUS_IDLE: begin
        // One stall cycle, then answer
        if (take) begin
          // Drop the stall for exactly the next cycle
          s_d.bus = BUS_ACK;
          s_d.waitrequest = 1'b0;
          s_d.rdata = '0;
          // Sample the read word now so it stands from a flop
          if (read) begin
            s_d.rdata[REG_W-1:0] = read_word(idx);
          end
        end
      end
      BUS_ACK: begin
        // Write lands on the edge the master sees us ready
        // Back to idle; a new request is answered a cycle later
        s_d.bus = BUS_IDLE;
        s_d.waitrequest = 1'b1;
        if (write) begin
          // Only the addressed register moves
          unique case (idx)
            IDX_LEFT_GAIN: begin
              // Level waits here for a commit
              s_d.left = unpack_gain(merged); // R1
            end
            IDX_RIGHT_GAIN: begin
              // Same for the right stage
              s_d.right = unpack_gain(merged); // R5
            end
            IDX_LEFT_MIX: begin
              // Takes effect on the mixer at once
              s_d.mix = unpack_mix(merged);
            end
            default: begin
              // Status and holes ignore writes
              s_d.mix = s_q.mix; // R15
            end
          endcase
          // Commit bit in either gain word commits both
          // Bit 8 sits in lane 1, so that lane must be enabled
          if (byteenable[1] && writedata[GAIN_COMMIT_BIT] &&
              (idx == IDX_LEFT_GAIN || idx == IDX_RIGHT_GAIN)) begin
            s_d.commit = 1'b1; // R6
          end
        end
      end
    endcase
  end

  // State register with documented reset values
  always_ff @(posedge clock) begin
    if (rst) begin
      // Bus idle and stalling
      s_q.bus <= BUS_IDLE;
      s_q.waitrequest <= 1'b1;
      s_q.rdata <= '0;
      // Left stage off, unmuted, 0dB
      s_q.left.on <= 1'b0; // R1
      s_q.left.silence <= 1'b0; // R2
      s_q.left.zero_cross <= 1'b0;
      s_q.left.level <= LEVEL_RESET; // R8
      // Right stage the same
      s_q.right.on <= 1'b0; // R5
      s_q.right.silence <= 1'b0;
      s_q.right.zero_cross <= 1'b0;
      s_q.right.level <= LEVEL_RESET; // R8
      // Only the left converter is selected
      s_q.mix <= MIX_RESET; // R11
      // No commit in flight
      s_q.commit <= 1'b0;
    end else begin
      // Whole state moves at once
      s_q <= s_d;
    end
  end

  // Gather per-stage inputs into arrays
  always_comb begin
    // Crossing detectors from the analogue side
    zc_in[CH_LEFT] = left_zero_cross;
    zc_in[CH_RIGHT] = right_zero_cross;
    // Deferral choice per stage
    zc_en[CH_LEFT] = s_q.left.zero_cross;
    zc_en[CH_RIGHT] = s_q.right.zero_cross;
    // Written levels, applied only on commit
    stage_target[CH_LEFT] = s_q.left.level;
    stage_target[CH_RIGHT] = s_q.right.level;
  end

  // One apply stage per channel; the commit is shared
  // A crossing input is taken as synchronous and clean; a
  // bouncing detector would release a deferred level early.
  for (genvar ch = 0; ch < CH_N; ch++) begin : g_stage
    gain_stage_apply u_apply (
      .clock(clock),
      .rst(rst),
      .commit(s_q.commit), // R6
      .target(stage_target[ch]),
      .zc_on(zc_en[ch]), // R4
      .zero_cross(zc_in[ch]),
      .level(stage_level[ch]),
      .qdb(stage_qdb[ch]),
      .pending(stage_pend[ch])
    );
  end

  // Bus answer straight from flops
  assign readdata = s_q.rdata;
  assign waitrequest = s_q.waitrequest;

  // Left stage controls; mute also cuts the record path
  // Enable and mute act at once; only the level waits
  assign left_gain.on = s_q.left.on; // R1
  assign left_gain.silence = s_q.left.silence; // R2
  assign left_gain.level = stage_level[CH_LEFT];
  assign left_gain.qdb = stage_qdb[CH_LEFT];
  assign left_gain.pending = stage_pend[CH_LEFT];

  // Right stage controls, same layout
  // Independent of the left stage except for the shared commit
  assign right_gain.on = s_q.right.on; // R5
  assign right_gain.silence = s_q.right.silence; // R5
  assign right_gain.level = stage_level[CH_RIGHT];
  assign right_gain.qdb = stage_qdb[CH_RIGHT];
  assign right_gain.pending = stage_pend[CH_RIGHT];

  // Mixer selection is the register itself
  // No commit for mixer bits: a select change is heard at once
  assign left_mix = s_q.mix; // R9

endmodule // input_gain_and_left_mixer_regs

/* File: tb/gain_mix_monitor.sv */
// Port-level checker for the gain and mixer register block
`timescale 1ns/1ps
module gain_mix_monitor (
  input wire logic clock,
  input wire logic rst,
  input wire logic [gain_mix_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [gain_mix_pkg::DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [gain_mix_pkg::DATA_W-1:0] readdata,
  input wire logic waitrequest,
  input wire logic left_zero_cross,
  input wire logic right_zero_cross,
  input wire gain_mix_pkg::gain_out_s left_gain,
  input wire gain_mix_pkg::gain_out_s right_gain,
  input wire gain_mix_pkg::mix_sel_s left_mix
);
  import gain_mix_pkg::*;
  logic rdy; // Write accepted this edge
  logic [7:0] idx; // Word index
  logic commit; // Commit bit written
  logic lcom; // Commit with left level
  assign rdy = write && !waitrequest;
  assign idx = address[9:2];
  assign commit = rdy && byteenable[1] && writedata[8] &&
    (idx == IDX_LEFT_GAIN || idx == IDX_RIGHT_GAIN);
  assign lcom = commit && idx == IDX_LEFT_GAIN && byteenable[0];
  // One clock domain for every property
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_left_ctrl_bits: assert property (rdy && idx == IDX_LEFT_GAIN &&
    byteenable[1] |=> left_gain.on == $past(writedata[15]) &&
    left_gain.silence == $past(writedata[14])) else $error("left ctrl");
  a_right_ctrl_bits: assert property (rdy && idx == IDX_RIGHT_GAIN &&
    byteenable[1] |=> right_gain.on == $past(writedata[15]) &&
    right_gain.silence == $past(writedata[14])) else $error("right ctrl");
  a_mix_upper_bits: assert property (rdy && idx == IDX_LEFT_MIX &&
    byteenable[1] |=> {left_mix.on, left_mix.right_converter_to_left_mix,
    left_mix.left_converter_to_left_mix} == $past({writedata[15],
    writedata[12:11]})) else $error("mix upper");
  a_mix_lower_bits: assert property (rdy && idx == IDX_LEFT_MIX &&
    byteenable[0] |=> {left_mix.aux_left_to_left_mix,
    left_mix.right_gain_to_left_mix, left_mix.left_gain_to_left_mix} ==
    $past(writedata[2:0])) else $error("mix lower");
  a_gain_law_left: assert property (
    left_gain.qdb == 9'(left_gain.level * 3) + GAIN_FLOOR_QDB)
    else $error("gain law");
  a_commit_direct: assert property (lcom && !writedata[13] |-> ##2
    left_gain.level == $past(writedata[7:2], 2) && !left_gain.pending)
    else $error("direct apply");
  a_commit_deferred: assert property (lcom && writedata[13] |-> ##2
    left_gain.pending) else $error("no defer");
  a_level_held: assert property ($changed(left_gain.level) |->
    $past(commit, 2) || $past(left_gain.pending)) else $error("early level");
  a_crossing_release: assert property (left_gain.pending &&
    left_zero_cross && !commit && !$past(commit) |=> !left_gain.pending)
    else $error("pending stuck");
  a_read_upper_zero: assert property (read && !waitrequest |->
    readdata[31:16] == 16'h0000) else $error("upper read bits");
  a_right_release: assert property (right_gain.pending &&
    right_zero_cross && !commit && !$past(commit) |=> !right_gain.pending)
    else $error("right pending stuck");
endmodule // gain_mix_monitor

bind input_gain_and_left_mixer_regs gain_mix_monitor i_gain_mix_monitor (
  .clock(clock), .rst(rst), .address(address), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .left_zero_cross(left_zero_cross),
  .right_zero_cross(right_zero_cross), .left_gain(left_gain),
  .right_gain(right_gain), .left_mix(left_mix));

/* File: tb/tb_top.sv */
// Self-checking bench for the gain and mixer register block
`timescale 1ns/1ps
module tb_top;
  import gain_mix_pkg::*;
  logic clock, rst, read, write, left_zero_cross, right_zero_cross;
  logic [ADDR_W-1:0] address;
  logic [DATA_W-1:0] writedata, readdata, rd;
  logic [3:0] byteenable;
  logic waitrequest;
  gain_out_s left_gain, right_gain;
  mix_sel_s left_mix;
  int fail_count, n_tests;

  input_gain_and_left_mixer_regs i_input_gain_and_left_mixer_regs (
    .clock(clock), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .left_zero_cross(left_zero_cross), .right_zero_cross(right_zero_cross),
    .left_gain(left_gain), .right_gain(right_gain), .left_mix(left_mix));

  // 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Bus access held until waitrequest is seen low; the watchdog cuts a hang
  task automatic access(input logic wr, input logic [7:0] a,
    input logic [31:0] d, input logic [3:0] be);
    @(posedge clock);
    address <= {a, 2'b00};
    writedata <= d;
    byteenable <= be;
    read <= !wr;
    write <= wr;
    do @(posedge clock); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
    access(1'b0, a, 32'h0, 4'hF);
    check(rd, exp);
  endtask

  // Values straight after reset
  task automatic t_reset;
    check(32'(left_mix), 32'(MIX_RESET));
    check(32'({left_gain.on, left_gain.silence, left_gain.level}),
      32'h10);
    check(32'({right_gain.on, right_gain.silence, right_gain.level}),
      32'h10);
    rd_check(IDX_LEFT_GAIN, 32'h40);
    rd_check(IDX_LEFT_MIX, 32'h800);
  endtask

  // Walk a single source select through every mixer bit
  task automatic t_mix;
    int pos[6];
    pos = '{15, 12, 11, 2, 1, 0};
    for (int i = 0; i < 6; i++) begin
      access(1'b1, IDX_LEFT_MIX, 32'h1 << pos[i], 4'h3);
      tick(1);
      check(32'(left_mix), 32'h1 << (5 - i));
      rd_check(IDX_LEFT_MIX, 32'h1 << pos[i]);
    end
    access(1'b1, IDX_LEFT_MIX, 32'hFFFF_FFFF, 4'hF);
    rd_check(IDX_LEFT_MIX, 32'h9807);
    rd_check(8'h70, 32'h0);
  endtask

  // Enable and mute per channel; level must not move without commit
  task automatic t_ctrl;
    access(1'b1, IDX_LEFT_GAIN, 32'hC0FF, 4'h3);
    tick(1);
    check(32'({left_gain.on, left_gain.silence, left_gain.level}),
      32'hD0);
    check(32'({right_gain.on, right_gain.silence}), 32'h0);
    access(1'b1, IDX_RIGHT_GAIN, 32'h8000, 4'h2);
    tick(1);
    check(32'({right_gain.on, right_gain.silence}), 32'h2);
    check(32'(left_gain.silence), 32'h1);
    rd_check(IDX_LEFT_GAIN, 32'hC0FC);
  endtask

  // Commit through the right register applies both levels
  task automatic t_commit;
    access(1'b1, IDX_RIGHT_GAIN, 32'h8100, 4'h3);
    tick(2);
    check(32'({left_gain.level, left_gain.qdb}), 32'h7E8D);
    check(32'({right_gain.level, right_gain.qdb}), 32'h1D0);
    rd_check(IDX_RIGHT_GAIN, 32'h8000);
  endtask

  // Left zero-cross defers the level until a crossing
  task automatic t_zc;
    access(1'b1, IDX_LEFT_GAIN, 32'hE114, 4'h3);
    tick(4);
    check(32'({left_gain.pending, left_gain.level}), 32'h7F);
    left_zero_cross <= 1'b1;
    tick(1);
    left_zero_cross <= 1'b0;
    tick(2);
    check(32'({left_gain.pending, left_gain.level}), 32'h05);
  endtask

  // Right deferral with the left deferred again by the shared commit, status of both waits, then a direct left apply
  task automatic t_right_zc;
    access(1'b1, IDX_RIGHT_GAIN, 32'hA108, 4'h3);
    tick(4);
    check(32'({right_gain.pending, right_gain.level}), 32'h40);
    rd_check(IDX_GAIN_STATUS, 32'hC005);
    right_zero_cross <= 1'b1;
    tick(1);
    right_zero_cross <= 1'b0;
    tick(2);
    check(32'({right_gain.pending, right_gain.level}), 32'h02);
    check(32'(left_gain.pending), 32'h1);
    access(1'b1, IDX_LEFT_GAIN, 32'hC108, 4'h3);
    tick(2);
    check(32'({left_gain.pending, left_gain.level, left_gain.qdb}),
      32'h05D6);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    {read, write, left_zero_cross, right_zero_cross} = 4'h0;
    address = '0;
    writedata = '0;
    byteenable = 4'h0;
    fail_count = 0;
    n_tests = 0;
    tick(5);
    rst <= 1'b0;
    tick(1);
    t_reset;
    t_mix;
    t_ctrl;
    t_commit;
    t_zc;
    t_right_zc;
    report_and_stop;
  end

  // Watchdog: the run needs about 110 cycles
  initial begin
    tick(3000);
    fail_count++;
    report_and_stop;
  end
endmodule // tb_top
